// >>> esc_pkg.sv
package esc_pkg;
    // register byte offsets
    localparam logic [7:0] A_MISC = 8'h00;
    localparam logic [7:0] A_SCMISC = 8'h04;
    localparam logic [7:0] A_SEED = 8'h10;
    localparam logic [7:0] A_FRQ2 = 8'h18; // read osc2 count, write min limit
    localparam logic [7:0] A_FRQ = 8'h1c; // read freq count, write max limit
    localparam logic [7:0] A_SCM = 8'h20; // read monobit count, write limit
    localparam logic [7:0] A_ENT_FIRST = 8'h40;
    localparam logic [7:0] A_ENT_LAST = 8'h5c;
    localparam logic [7:0] A_INTCTRL = 8'ha0;
    localparam logic [7:0] A_INTMASK = 8'ha4;
    localparam logic [7:0] A_INTSTAT = 8'ha8;
    // misc_control_reg bit positions
    localparam int MC_PROG = 16;
    localparam int MC_TSTOP = 13;
    localparam int MC_ERR = 12;
    localparam int MC_ENTVAL = 10;
    localparam int MC_FCT = 8;
    localparam int MC_ACC = 5;
    // interrupt bit positions
    localparam int IRQ_FCT = 0;
    localparam int IRQ_ENT = 1;
    localparam int IRQ_HW = 2;
    // reset values and bus response codes
    localparam logic [31:0] SCMISC_RST = 32'h0001001f;
    localparam logic [31:0] SEED_RST = 32'h0c800200;
    localparam logic [31:0] FRQMIN_RST = 32'h00000640;
    localparam logic [31:0] FRQMAX_RST = 32'h00006400;
    localparam logic [31:0] SCML_RST = 32'h0078013c;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_START = 3'b010,
        S_GEN = 3'b100
    } esc_state_t;

    typedef struct packed {
        logic [15:0] entDelay;
        logic [15:0] monoMax;
        logic [15:0] monoRange;
        logic [7:0] longRunMax;
        logic [31:0] frqMin;
        logic [31:0] frqMax;
    } esc_cfg_t;

    typedef struct packed {
        logic bitStrobe;
        logic bitVal;
        logic done;
        logic statFail;
        logic freqFail;
        logic [31:0] freq;
        logic [31:0] freq2;
        logic [15:0] ones;
    } esc_res_t;

    function automatic logic inRange(input logic [31:0] v, input logic [31:0] lo,
                                     input logic [31:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction
endpackage

// >>> esc_sampler.sv
`timescale 1ns/1ps
module esc_sampler import esc_pkg::*; #(
    parameter int NBITS = 256
) (
    input wire logic mclk, // bus clock
    input wire logic srst, // sync reset
    input wire logic start, // begin a new block
    input wire logic abort, // stop at once
    input esc_cfg_t cfg, // programmed parameters
    input wire logic oscIn, // ring oscillator 1
    input wire logic osc2In, // ring oscillator 2
    output esc_res_t res // bits and test results
);
    localparam int IW = $clog2(NBITS) + 1;
    localparam logic [IW-1:0] LAST = IW'(NBITS - 1);

    logic busy, oscPrev, osc2Prev, lastBit, runFail, frqFail;
    logic [15:0] tmr, ones, nextOnes;
    logic [31:0] cnt, cnt2, thisCnt, thisCnt2;
    logic [IW-1:0] bitIdx;
    logic [7:0] run, nextRun;
    logic tick, isLast, monoOk;

    // edge counts include the edge seen in the closing cycle
    assign tick = busy && (tmr <= 16'h0001);
    assign isLast = bitIdx == LAST;
    assign thisCnt = cnt + {31'h0, oscIn & ~oscPrev};
    assign thisCnt2 = cnt2 + {31'h0, osc2In & ~osc2Prev};
    assign nextOnes = ones + {15'h0, thisCnt[0]};
    assign nextRun = (bitIdx != '0 && thisCnt[0] == lastBit) ?
                     ((run == 8'hff) ? run : run + 8'h01) : 8'h01;
    assign monoOk = inRange({16'h0, nextOnes}, {16'h0, cfg.monoMax - cfg.monoRange},
                            {16'h0, cfg.monoMax});

    always_ff @(posedge mclk) begin
        oscPrev <= oscIn;
        osc2Prev <= osc2In;
    end

    // sampling period timer, one entropy bit per period
    always_ff @(posedge mclk) begin
        if (srst || abort) begin
            busy <= 1'b0;
            tmr <= 16'h0;
            bitIdx <= '0;
        end else if (start) begin
            busy <= 1'b1;
            tmr <= cfg.entDelay;
            bitIdx <= '0;
        end else if (tick) begin
            tmr <= cfg.entDelay;
            bitIdx <= bitIdx + IW'(1);
            if (isLast) busy <= 1'b0;
        end else if (busy) begin
            tmr <= tmr - 16'h0001;
        end
    end

    // oscillator edge counters over one period
    always_ff @(posedge mclk) begin
        if (srst || start || tick) begin
            cnt <= 32'h0;
            cnt2 <= 32'h0;
        end else if (busy) begin
            cnt <= thisCnt;
            cnt2 <= thisCnt2;
        end
    end

    // running health tests: monobit, long run, frequency window
    always_ff @(posedge mclk) begin
        if (srst || start) begin
            ones <= 16'h0;
            run <= 8'h0;
            lastBit <= 1'b0;
            runFail <= 1'b0;
            frqFail <= 1'b0;
        end else if (tick) begin
            ones <= nextOnes;
            run <= nextRun;
            lastBit <= thisCnt[0];
            if (nextRun > cfg.longRunMax) runFail <= 1'b1;
            if (!inRange(thisCnt, cfg.frqMin, cfg.frqMax)) frqFail <= 1'b1;
        end
    end

    // the count's lsb carries the jitter, so it is the entropy bit
    always_ff @(posedge mclk) begin
        if (srst) begin
            res <= '0;
        end else begin
            res.bitStrobe <= tick && !abort; // no bit escapes once halted
            res.done <= tick && isLast && !abort;
            if (tick) begin
                res.bitVal <= thisCnt[0];
                res.freq <= thisCnt;
                res.freq2 <= thisCnt2;
            end
            if (tick && isLast) begin
                res.ones <= nextOnes;
                res.statFail <= !monoOk || runFail || (nextRun > cfg.longRunMax);
                res.freqFail <= frqFail || !inRange(thisCnt, cfg.frqMin, cfg.frqMax);
            end
        end
    end
endmodule

// >>> esc_top.sv
`timescale 1ns/1ps
module esc_top import esc_pkg::*; #(
    parameter int NBITS = 256
) (
    input wire logic mclk, // bus clock
    input wire logic srst, // sync reset, active high
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [7:0] awaddr, // write byte address
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte enables, full word only
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    output logic [1:0] bresp, // write response
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    input wire logic [7:0] araddr, // read byte address
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    input wire logic oscIn, // ring oscillator 1
    input wire logic osc2In, // ring oscillator 2
    output logic irq // masked interrupt, active high
);
    localparam int NWORDS = NBITS / 32;
    localparam int BW = $clog2(NBITS);

    esc_state_t state;
    esc_cfg_t cfg;
    esc_res_t res;
    logic prog, acc, errFlag, entValid, fctFail;
    logic [31:0] scmisc, seedCtl, frqMin, frqMax, scml;
    logic [31:0] freqCount, osc2Cnt, monoCnt, wDataQ, rdVal, miscView;
    logic [7:0] awAddrQ;
    logic [31:0] entWord [NWORDS];
    logic [BW-1:0] bitCnt;
    logic [3:0] retryLeft;
    logic [2:0] intStatus, intMask, intEvt, intClr;
    logic awHs, wHs, arHs, weDo, run, rdEntLast, rdErr, isEnt, sampFail, genEnd;

    assign awHs = awvalid && awready;
    assign wHs = wvalid && wready;
    assign arHs = arvalid && arready;
    assign weDo = !awready && !wready && !bvalid;
    assign run = !prog && acc;
    assign isEnt = (araddr >= A_ENT_FIRST) && (araddr <= A_ENT_LAST) && (araddr[1:0] == 2'b00);
    assign rdEntLast = arHs && (araddr == A_ENT_LAST) && acc;
    assign sampFail = res.statFail || res.freqFail;
    assign genEnd = (state == S_GEN) && run && res.done && !(sampFail && retryLeft != 4'h0);

    ////////////////////////////////////////////////////////////////////////////
    // bus write channels: address and data taken in either order
    always_ff @(posedge mclk) begin
        if (srst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            awAddrQ <= 8'h0;
            wDataQ <= 32'h0;
        end else begin
            if (awHs) begin
                awready <= 1'b0;
                awAddrQ <= awaddr;
            end
            if (wHs) begin
                wready <= 1'b0;
                wDataQ <= wdata;
            end
            if (weDo) bvalid <= 1'b1;
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // status view of misc_control_reg
    always_comb begin
        miscView = 32'h0;
        miscView[MC_PROG] = prog;
        miscView[MC_TSTOP] = (state == S_IDLE);
        miscView[MC_ERR] = errFlag;
        miscView[MC_ENTVAL] = entValid;
        miscView[MC_FCT] = fctFail;
        miscView[MC_ACC] = acc;
    end

    // read decode; limit registers share offsets with counts and are write-only
    always_comb begin
        rdVal = 32'h0;
        rdErr = 1'b0;
        if (isEnt) begin
            if (!acc) rdErr = 1'b1;
            else if (entValid) rdVal = entWord[araddr[4:2]];
        end else begin
            unique case (araddr)
                A_MISC: rdVal = miscView;
                A_SCMISC: rdVal = scmisc;
                A_SEED: rdVal = seedCtl;
                A_FRQ2: rdVal = osc2Cnt;
                A_FRQ: rdVal = freqCount;
                A_SCM: rdVal = monoCnt;
                A_INTCTRL: rdVal = {29'h0, intStatus};
                A_INTMASK: rdVal = {29'h0, intMask};
                A_INTSTAT: rdVal = {29'h0, intStatus & intMask};
                default: rdErr = 1'b1;
            endcase
        end
    end

    // read channel, one read outstanding
    always_ff @(posedge mclk) begin
        if (srst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
        end else if (arHs) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rdVal;
            rresp <= rdErr ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode and access bits are writable in either mode
    always_ff @(posedge mclk) begin
        if (srst) begin
            prog <= 1'b1;
            acc <= 1'b0;
        end else if (weDo && awAddrQ == A_MISC) begin
            prog <= wDataQ[MC_PROG];
            acc <= wDataQ[MC_ACC];
        end
    end

    // completion flags; a hardware set beats a software clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            errFlag <= 1'b0;
            fctFail <= 1'b0;
            entValid <= 1'b0;
        end else begin
            if (genEnd && sampFail) errFlag <= 1'b1;
            else if (weDo && awAddrQ == A_MISC && (wDataQ[MC_ERR] || wDataQ[MC_PROG]))
                errFlag <= 1'b0;
            if (genEnd && res.freqFail) fctFail <= 1'b1;
            else if (weDo && awAddrQ == A_MISC && (wDataQ[MC_FCT] || wDataQ[MC_PROG]))
                fctFail <= 1'b0;
            if (genEnd && !sampFail) entValid <= 1'b1;
            else if (rdEntLast || prog) entValid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: idle (ok to stop), start pulse, generating
    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= S_IDLE;
        end else begin
            unique case (state)
                S_IDLE: if (run && !entValid && !errFlag) state <= S_START;
                S_START: state <= run ? S_GEN : S_IDLE;
                S_GEN: begin
                    if (!run) state <= S_IDLE;
                    else if (res.done)
                        state <= (sampFail && retryLeft != 4'h0) ? S_START : S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // retries left before a failed block is reported
    always_ff @(posedge mclk) begin
        if (srst) retryLeft <= 4'h0;
        else if (state == S_IDLE) retryLeft <= scmisc[19:16];
        else if (state == S_GEN && res.done && sampFail && retryLeft != 4'h0)
            retryLeft <= retryLeft - 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration is frozen outside programming mode
    always_ff @(posedge mclk) begin
        if (srst) begin
            scmisc <= SCMISC_RST;
            seedCtl <= SEED_RST;
            frqMin <= FRQMIN_RST;
            frqMax <= FRQMAX_RST;
            scml <= SCML_RST;
        end else if (weDo && prog) begin
            unique case (awAddrQ)
                A_SCMISC: scmisc <= wDataQ;
                A_SEED: seedCtl <= wDataQ;
                A_FRQ2: frqMin <= wDataQ;
                A_FRQ: frqMax <= wDataQ;
                A_SCM: scml <= wDataQ;
                default: ;
            endcase
        end
    end

    always_comb begin
        cfg.entDelay = seedCtl[31:16];
        cfg.monoMax = scml[15:0];
        cfg.monoRange = scml[31:16];
        cfg.longRunMax = scmisc[7:0];
        cfg.frqMin = frqMin;
        cfg.frqMax = frqMax;
    end

    esc_sampler #(.NBITS(NBITS)) u_sampler (
        .mclk(mclk),
        .srst(srst),
        .start(state == S_START),
        .abort(!run),
        .cfg(cfg),
        .oscIn(oscIn),
        .osc2In(osc2In),
        .res(res)
    );

    ////////////////////////////////////////////////////////////////////////////
    // entropy store; wiped on restart, discard or return to programming
    always_ff @(posedge mclk) begin
        if (srst || state == S_START || rdEntLast || prog) begin
            for (int i = 0; i < NWORDS; i++) entWord[i] <= 32'h0;
            bitCnt <= '0;
        end else if (res.bitStrobe) begin
            entWord[bitCnt[BW-1:5]][bitCnt[4:0]] <= res.bitVal;
            bitCnt <= bitCnt + BW'(1);
        end
    end

    // edge counters: a new sample beats the clear-on-read; monobit count is not cleared on read
    always_ff @(posedge mclk) begin
        if (srst) begin
            freqCount <= 32'h0;
            osc2Cnt <= 32'h0;
            monoCnt <= 32'h0;
        end else begin
            if (res.bitStrobe) freqCount <= res.freq;
            else if (arHs && araddr == A_FRQ) freqCount <= 32'h0;
            if (res.bitStrobe) osc2Cnt <= res.freq2;
            else if (arHs && araddr == A_FRQ2) osc2Cnt <= 32'h0;
            if (res.done) monoCnt <= {16'h0, res.ones};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt sources mirror the flag set events; write 0 clears
    always_comb begin
        intEvt = 3'b000;
        intEvt[IRQ_FCT] = genEnd && res.freqFail;
        intEvt[IRQ_ENT] = genEnd && !sampFail;
        intEvt[IRQ_HW] = genEnd && sampFail;
        intClr = (weDo && awAddrQ == A_INTCTRL) ? ~wDataQ[2:0] : 3'b000;
        intClr[IRQ_ENT] = intClr[IRQ_ENT] | rdEntLast;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            intStatus <= 3'b000;
            intMask <= 3'b000;
            irq <= 1'b0;
        end else begin
            intStatus <= (intStatus & ~intClr) | intEvt;
            if (weDo && awAddrQ == A_INTMASK) intMask <= wDataQ[2:0];
            irq <= |(intStatus & intMask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_reset_prog;
        @(posedge mclk) disable iff (srst) $past(srst) |-> prog && miscView[MC_TSTOP];
    endproperty
    a_reset_prog: assert property (p_reset_prog) else $error("not in prog after reset");

    property p_tstop_reset;
        @(posedge mclk) disable iff (srst) $past(srst) |-> rdVal[MC_TSTOP] || araddr != A_MISC;
    endproperty
    a_tstop_reset: assert property (p_tstop_reset) else $error("ok-to-stop low");

    property p_quiet_prog;
        @(posedge mclk) disable iff (srst) prog [*2] |=> !res.bitStrobe;
    endproperty
    a_quiet_prog: assert property (p_quiet_prog) else $error("bit made in prog");

    property p_start_run;
        @(posedge mclk) disable iff (srst)
            $fell(prog) && acc && state == S_IDLE && !entValid && !errFlag
            |=> state == S_START;
    endproperty
    a_start_run: assert property (p_start_run) else $error("run did not start");

    property p_halt_prog;
        @(posedge mclk) disable iff (srst) prog |=> state == S_IDLE;
    endproperty
    a_halt_prog: assert property (p_halt_prog) else $error("gen in prog");

    property p_halt_acc;
        @(posedge mclk) disable iff (srst) !acc |=> state == S_IDLE && !res.done;
    endproperty
    a_halt_acc: assert property (p_halt_acc) else $error("gen without access");

    property p_valid_end;
        @(posedge mclk) disable iff (srst)
            state == S_GEN && run && res.done && !sampFail |=> entValid && !errFlag;
    endproperty
    a_valid_end: assert property (p_valid_end) else $error("valid flag missing");

    property p_ent_locked;
        @(posedge mclk) disable iff (srst)
            arHs && isEnt && !acc |=> rvalid && rdata == 32'h0 && rresp == RESP_SLVERR;
    endproperty
    a_ent_locked: assert property (p_ent_locked) else $error("entropy leaked");

    property p_discard;
        @(posedge mclk) disable iff (srst)
            rdEntLast && state == S_IDLE && !errFlag ##1 run |=> state == S_START && !entValid;
    endproperty
    a_discard: assert property (p_discard) else $error("no regen after last");

    property p_frq_clear;
        @(posedge mclk) disable iff (srst)
            arHs && araddr == A_FRQ && !res.bitStrobe |=> freqCount == 32'h0;
    endproperty
    a_frq_clear: assert property (p_frq_clear) else $error("count not cleared");

    property p_cfg_frozen;
        @(posedge mclk) disable iff (srst)
            weDo && !prog && awAddrQ == A_SEED |=> $stable(seedCtl);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen) else $error("cfg written in run");

    property p_mask_reset;
        @(posedge mclk) disable iff (srst) $past(srst) |-> intMask == 3'b000 && !irq;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("irq enabled at reset");
endmodule

// >>> entropy_source_control_test.sv
`timescale 1ns/1ps
`define CK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module entropy_source_control_test import esc_pkg::*;;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic oscIn = 1'b0;
    logic osc2In = 1'b0;
    logic oscRun = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rr;
    logic [31:0] rdata, rv, sdM;
    logic [31:0] entQ[$];
    int fails = 0;
    int checks_done = 0;
    int seed = 32'h014afaa9;

    esc_top u_dut (.mclk, .srst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
        .rready, .rdata, .rresp, .oscIn, .osc2In, .irq);

    ////////////////////////////////////////////////////////////////////////////////
    // 100 ns bus clock
    initial forever #50 mclk = ~mclk;

    // toggling oscillator gives one rising edge per two-cycle sample period
    always @(posedge mclk) begin
        oscIn <= oscRun & ~oscIn;
        osc2In <= oscRun & ~oscIn;
    end

    // hang guard, far beyond the few thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        // an edge between transfers so ready is never driven twice at once
        @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        rd(a);
        `CK(rv, e)
        `CK(rr, r)
    endtask

    // poll until the generator reports idle
    task automatic waitDone;
        repeat (4) @(posedge mclk);
        do rd(A_MISC); while (!rv[MC_TSTOP]);
    endtask

    // model words leave the queue in read order, last word last
    task automatic readEnt;
        for (int i = 0; i < 8; i++) begin
            rc(A_ENT_FIRST + 8'(4 * i), entQ.pop_front(), RESP_OKAY);
        end
    endtask

    task automatic test_done;
        $display("fails %0d checks %0d", fails, checks_done);
        if (fails == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        rc(A_MISC, 32'h00012000, RESP_OKAY);
        rc(A_INTMASK, 32'h0, RESP_OKAY);
        rc(8'hfc, 32'h0, RESP_SLVERR);
        rc(A_ENT_FIRST, 32'h0, RESP_SLVERR);
        $display("test reset done");
        // short bit period, limits wide open
        sdM = {16'h0002, 16'($random(seed))};
        wr(A_SEED, sdM);
        wr(A_FRQ2, 32'h0);
        wr(A_FRQ, 32'hffffffff);
        wr(A_SCM, 32'h01000100);
        // long-run limit at its ceiling: a steady oscillator gives equal bits
        wr(A_SCMISC, 32'h000100ff);
        wr(A_INTMASK, 32'h2);
        rc(A_SEED, sdM, RESP_OKAY);
        rc(A_SCMISC, 32'h000100ff, RESP_OKAY);
        rd(A_FRQ);
        rc(A_FRQ, 32'h0, RESP_OKAY);
        wr(A_MISC, 32'h00010020);
        rc(A_ENT_FIRST, 32'h0, RESP_OKAY);
        rc(A_MISC, 32'h00012020, RESP_OKAY);
        $display("test program done");
        oscRun <= 1'b1;
        repeat (8) entQ.push_back(32'hffffffff);
        wr(A_MISC, 32'h00000020);
        wr(A_SEED, 32'($random(seed)));
        waitDone;
        rc(A_MISC, 32'h00002420, RESP_OKAY);
        `CK(irq, 1'b1)
        rc(A_SEED, sdM, RESP_OKAY);
        // one oscillator edge per two-cycle period; a read then zeroes each count
        rc(A_FRQ, 32'h1, RESP_OKAY);
        rc(A_FRQ, 32'h0, RESP_OKAY);
        rc(A_FRQ2, 32'h1, RESP_OKAY);
        rc(A_FRQ2, 32'h0, RESP_OKAY);
        rc(A_SCM, 32'h100, RESP_OKAY);
        oscRun <= 1'b0;
        readEnt;
        rc(A_INTSTAT, 32'h0, RESP_OKAY);
        `CK(irq, 1'b0)
        repeat (8) entQ.push_back(32'h0);
        waitDone;
        readEnt;
        $display("test blocks done");
        wr(A_MISC, 32'h00010020);
        rc(A_MISC, 32'h00012020, RESP_OKAY);
        rc(A_ENT_FIRST, 32'h0, RESP_OKAY);
        // frequency floor above any count forces a failed block
        wr(A_FRQ2, 32'h00000010);
        wr(A_MISC, 32'h00000020);
        waitDone;
        rc(A_MISC, 32'h00003120, RESP_OKAY);
        rc(A_INTCTRL, 32'h5, RESP_OKAY);
        wr(A_INTCTRL, 32'h2);
        rc(A_INTCTRL, 32'h0, RESP_OKAY);
        wr(A_MISC, 32'h00010020);
        wr(A_FRQ2, 32'h0);
        wr(A_MISC, 32'h00000020);
        repeat (20) @(posedge mclk);
        wr(A_MISC, 32'h0);
        repeat (600) @(posedge mclk);
        rc(A_MISC, 32'h00002000, RESP_OKAY);
        rc(A_ENT_FIRST, 32'h0, RESP_SLVERR);
        $display("test stop done");
        test_done();
    end
endmodule
